// ==== rtl/flc_pkg.sv ====
// flc_pkg: constants, codes and lookup tables of the flash LED control registers
// assumes a 100 MHz system clock and byte-wide registers behind a simple strobe port
package flc_pkg;

  // ************************************************************
  // register map and field positions
  // ************************************************************
  localparam logic [7:0] ADDR_MODE_COPY  = 8'h01;
  localparam logic [7:0] ADDR_FLASH      = 8'h02;
  localparam logic [7:0] ADDR_TIMER      = 8'h03;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h11;

  localparam int B_VM      = 7;
  localparam int B_MODE_LO = 5;
  localparam int B_FC13_LO = 3;
  localparam int B_FC2_LO  = 0;
  localparam int B_STIM_LO = 5;
  localparam int B_FAIL    = 4;
  localparam int B_TO      = 3;
  localparam int B_STT     = 2;
  localparam int B_SFT     = 1;
  localparam int B_TXM     = 0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic       RST_VM    = 1'h0;
  localparam logic [1:0] RST_FC13  = 2'h0;
  localparam logic [2:0] RST_FC2   = 3'h3;
  localparam logic [2:0] RST_STIM  = 3'h6;
  localparam logic       RST_RANGE = 1'h0;
  localparam logic       RST_STT   = 1'h0;
  localparam logic       RST_TXM   = 1'h1;

  // ************************************************************
  // modes, states, interrupt and pin indices
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_DC       = 2'h1,
    MODE_FLASH    = 2'h2,
    MODE_VSRC     = 2'h3
  } flc_mode_t;

  typedef enum logic [2:0] {
    FL_IDLE  = 3'h1,
    FL_LEVEL = 3'h2,
    FL_SHOT  = 3'h4
  } flc_flash_t;

  localparam int IRQ_FAIL  = 0;
  localparam int IRQ_TO    = 1;
  localparam int IRQ_BLANK = 2;
  localparam int IRQ_WDOG  = 3;
  localparam int IRQ_W     = 4;

  localparam int SYN_VM    = 0;
  localparam int SYN_HC    = 1;
  localparam int SYN_TXM   = 2;
  localparam int SYN_FAULT = 3;
  localparam int SYN_FSYNC = 4;
  localparam int SYN_W     = 5;

  // ************************************************************
  // timing: timers count ticks of 0.1 ms
  // ************************************************************
  localparam int  CLK_PERIOD_NS  = 10;
  localparam int  TICK_TIME_NS   = 100000;
  localparam int  TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam real WDOG_TIME_S    = 11.2;
  localparam int  WDOG_TICKS_DEF = $rtoi((WDOG_TIME_S * 1.0e9 + 0.5) / TICK_TIME_NS);

  // ************************************************************
  // lookup tables
  // ************************************************************
  function automatic logic [11:0] outer_ma(input logic hc, input logic [1:0] code);
    case ({hc, code})
      3'h0:    outer_ma = 12'h113;
      3'h1:    outer_ma = 12'h14f;
      3'h2:    outer_ma = 12'h181;
      3'h3:    outer_ma = 12'h1bd;
      3'h4:    outer_ma = 12'h299;
      3'h5:    outer_ma = 12'h307;
      3'h6:    outer_ma = 12'h37a;
      default: outer_ma = 12'h401;
    endcase
  endfunction

  function automatic logic [11:0] centre_ma(input logic hc, input logic [2:0] code);
    case ({hc, code})
      4'h0:    centre_ma = 12'h131;
      4'h1:    centre_ma = 12'h14f;
      4'h2:    centre_ma = 12'h181;
      4'h3:    centre_ma = 12'h1f4;
      4'h4:    centre_ma = 12'h262;
      4'h5:    centre_ma = 12'h299;
      4'h6:    centre_ma = 12'h307;
      4'h7:    centre_ma = 12'h375;
      4'h8:    centre_ma = 12'h2d0;
      4'h9:    centre_ma = 12'h307;
      4'ha:    centre_ma = 12'h393;
      4'hb:    centre_ma = 12'h48d;
      4'hc:    centre_ma = 12'h5aa;
      4'hd:    centre_ma = 12'h60e;
      4'he:    centre_ma = 12'h6ef;
      default: centre_ma = 12'h802;
    endcase
  endfunction

  // safety time in ticks of 0.1 ms
  function automatic logic [15:0] safety_ticks(input logic range_sel, input logic [2:0] code);
    case ({range_sel, code})
      4'h0:    safety_ticks = 16'h02aa;
      4'h1:    safety_ticks = 16'h03fe;
      4'h2:    safety_ticks = 16'h0553;
      4'h3:    safety_ticks = 16'h06a8;
      4'h4:    safety_ticks = 16'h07fd;
      4'h5:    safety_ticks = 16'h0d50;
      4'h6:    safety_ticks = 16'h16a1;
      4'h7:    safety_ticks = 16'h2148;
      4'h8:    safety_ticks = 16'h0035;
      4'h9:    safety_ticks = 16'h006b;
      4'ha:    safety_ticks = 16'h00a0;
      4'hb:    safety_ticks = 16'h00d5;
      4'hc:    safety_ticks = 16'h010a;
      4'hd:    safety_ticks = 16'h0140;
      4'he:    safety_ticks = 16'h0175;
      default: safety_ticks = 16'h081d;
    endcase
  endfunction

endpackage

// ==== rtl/flc_timer_if.sv ====
// flc_timer_if: link between the register block and its flash safety timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface flc_timer_if;
  logic       start;
  logic       stop;
  logic       range_sel;
  logic [2:0] code;
  logic       running;
  logic       expired;
  modport ctl (output start, output stop, output range_sel, output code, input running, input expired);
  modport tmr (input start, input stop, input range_sel, input code, output running, output expired);
endinterface

// ==== rtl/flc_safety_timer.sv ====
// flc_safety_timer: flash safety timer, counts ticks up to the selected safety time
// assumes start and stop are one-cycle pulses from the register block
`timescale 1ns/1ps
module flc_safety_timer
  import flc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic clk,
  input  wire logic rst,
  flc_timer_if.tmr  tif
);

  typedef struct packed {
    logic [31:0] presc;
    logic [15:0] ticks;
    logic        running;
    logic        expired;
  } flc_tmr_state_t;

  flc_tmr_state_t q;
  flc_tmr_state_t next_q;

  // ************************************************************
  // counting
  // ************************************************************
  always_comb begin
    next_q         = q;
    next_q.expired = 1'b0;
    if (tif.start) begin
      next_q.running = 1'b1;
      next_q.presc   = '0;
      next_q.ticks   = '0;
    end else if (tif.stop) begin
      next_q.running = 1'b0;
    end else if (q.running) begin
      next_q.presc = q.presc + 32'h1;
      if (q.presc == 32'(TICK_CYCLES - 1)) begin
        next_q.presc = '0;
        next_q.ticks = q.ticks + 16'h1;
        if (q.ticks + 16'h1 >= safety_ticks(tif.range_sel, tif.code)) begin
          next_q.running = 1'b0;
          next_q.expired = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tif.running = q.running;
  assign tif.expired = q.expired;

endmodule

// ==== rtl/flc_regs.sv ====
// flc_regs: control and status registers of an LED flash driver
// assumes a host bridge driving one-cycle strobes and asynchronous pins from the board
//
// Behaviour
// - bit 7 forces voltage mode, reads pin
// - mode field decodes four operating modes
// - mode not refreshed in 11.2 s shuts down
// - mode write at 0x02 updates 0x01 copy
// - mode write at 0x01 updates 0x02
// - outer flash code picks current per range
// - centre flash code picks current per range
// - safety code picks timeout per range
// - led failure flag sticky, clears on read
// - timer bit 3 write selects range
// - timeout flag set on expiry, cleared restart
// - trigger type level or edge, flash mode
// - writing strobe one starts a flash
// - strobe bit reads flash in progress
// - blanking enable reduces current while pin high
// - blanking flag sticky, clears on read
`timescale 1ns/1ps
module flc_regs
  import flc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int WDOG_TICKS  = WDOG_TICKS_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        voltage_mode_pin,
  input  wire logic        high_current_select,
  input  wire logic        tx_mask_pin,
  input  wire logic        led_fault_pin,
  input  wire logic        flash_sync_pin,
  output logic      [1:0]  operating_mode,
  output logic             voltage_mode,
  output logic             flash_active,
  output logic             blanking,
  output logic      [11:0] outer_led_current_ma,
  output logic      [11:0] centre_led_current_ma,
  output logic             irq
);

  typedef struct packed {
    logic [SYN_W-1:0] s1;
    logic [SYN_W-1:0] s2;
    logic             fsync_prev;
    logic             voltage_mode_force;
    flc_mode_t        mode;
    logic [1:0]       outer_led_flash_level;
    logic [2:0]       centre_led_flash_level;
    logic [2:0]       safety_time_code;
    logic             timer_range_sel;
    logic             timer_trigger_type;
    logic             blank_en;
    logic             led_failure_flag;
    logic             timeout_flag;
    logic             blank_flag;
    logic             level_spent;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    flc_flash_t       fl;
    logic             start;
    logic             stop;
    logic [31:0]      wdog_presc;
    logic [31:0]      wdog_ticks;
    logic [7:0]       rdata;
    logic [1:0]       mode_out;
    logic             vm_out;
    logic             flash_out;
    logic             blank_out;
    logic [11:0]      outer_ma;
    logic [11:0]      centre_ma;
    logic             irq;
  } flc_regs_state_t;

  flc_regs_state_t q;
  flc_regs_state_t next_q;
  flc_timer_if     tif();

  // ************************************************************
  // safety timer
  // ************************************************************
  flc_safety_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk (clk),
    .rst (rst),
    .tif (tif)
  );

  assign tif.start     = q.start;
  assign tif.stop      = q.stop;
  assign tif.range_sel = q.timer_range_sel;
  assign tif.code      = q.safety_time_code;

  // ************************************************************
  // next state
  // ************************************************************
  logic             wr_copy;
  logic             wr_flash;
  logic             wr_timer;
  logic             rd_timer;
  logic             sw_start;
  logic             in_flash;
  logic             lvl;
  logic             rise;
  logic             wdog_evt;
  logic             fail_set;
  logic             blank_set;
  logic             blank_now;
  logic [IRQ_W-1:0] events;

  always_comb begin
    next_q            = q;
    next_q.s1         = {flash_sync_pin, led_fault_pin, tx_mask_pin, high_current_select, voltage_mode_pin};
    next_q.s2         = q.s1;
    next_q.fsync_prev = q.s2[SYN_FSYNC];
    next_q.start      = 1'b0;
    next_q.stop       = 1'b0;
    next_q.rdata      = 8'h00;
    wr_copy   = wr && (addr == ADDR_MODE_COPY);
    wr_flash  = wr && (addr == ADDR_FLASH);
    wr_timer  = wr && (addr == ADDR_TIMER);
    rd_timer  = rd && (addr == ADDR_TIMER);
    sw_start  = wr_timer && wdata[B_SFT];
    in_flash  = (q.mode == MODE_FLASH);
    lvl       = q.s2[SYN_FSYNC];
    rise      = q.s2[SYN_FSYNC] && !q.fsync_prev;
    wdog_evt  = 1'b0;
    fail_set  = q.s2[SYN_FAULT];
    blank_set = q.blank_en && q.s2[SYN_TXM];

    // mode refresh timeout, counts in every mode except shutdown
    if (wr_copy || wr_flash || (q.mode == MODE_SHUTDOWN)) begin
      next_q.wdog_presc = '0;
      next_q.wdog_ticks = '0;
    end else if (q.wdog_presc == 32'(TICK_CYCLES - 1)) begin
      next_q.wdog_presc = '0;
      next_q.wdog_ticks = q.wdog_ticks + 32'h1;
      if (q.wdog_ticks == 32'(WDOG_TICKS - 1)) begin
        next_q.mode = MODE_SHUTDOWN;
        wdog_evt    = 1'b1;
      end
    end else begin
      next_q.wdog_presc = q.wdog_presc + 32'h1;
    end

    // register writes
    if (wr_copy) begin
      next_q.mode = flc_mode_t'(wdata[B_MODE_LO +: 2]);
    end
    if (wr_flash) begin
      next_q.voltage_mode_force     = wdata[B_VM];
      next_q.mode                   = flc_mode_t'(wdata[B_MODE_LO +: 2]);
      next_q.outer_led_flash_level  = wdata[B_FC13_LO +: 2];
      next_q.centre_led_flash_level = wdata[B_FC2_LO +: 3];
    end
    if (wr_timer) begin
      next_q.safety_time_code   = wdata[B_STIM_LO +: 3];
      next_q.timer_range_sel    = wdata[B_TO];
      next_q.timer_trigger_type = wdata[B_STT];
      next_q.blank_en           = wdata[B_TXM];
    end
    if (wr && (addr == ADDR_IRQ_MASK)) begin
      next_q.irq_mask = wdata[IRQ_W-1:0];
    end

    // flash strobe sequencing
    if (!lvl) begin
      next_q.level_spent = 1'b0;
    end
    case (q.fl)
      FL_IDLE: begin
        if (in_flash && (sw_start || (q.timer_trigger_type && rise))) begin
          next_q.start = 1'b1;
          next_q.fl    = FL_SHOT;
        end else if (in_flash && !q.timer_trigger_type && lvl && !q.level_spent) begin
          next_q.start = 1'b1;
          next_q.fl    = FL_LEVEL;
        end
      end
      FL_LEVEL: begin
        if (!in_flash || !lvl) begin
          next_q.stop = 1'b1;
          next_q.fl   = FL_IDLE;
        end else if (tif.expired) begin
          next_q.level_spent = 1'b1;
          next_q.fl          = FL_IDLE;
        end
      end
      FL_SHOT: begin
        if (!in_flash) begin
          next_q.stop = 1'b1;
          next_q.fl   = FL_IDLE;
        end else if (sw_start || (q.timer_trigger_type && rise)) begin
          next_q.start = 1'b1;
        end else if (tif.expired && !q.start) begin
          next_q.fl = FL_IDLE;
        end
      end
      default: begin
        next_q.fl = FL_IDLE;
      end
    endcase

    // sticky flags, set wins over clear
    if (q.start) begin
      next_q.timeout_flag = 1'b0;
    end
    if (tif.expired) begin
      next_q.timeout_flag = 1'b1;
    end
    if (rd_timer) begin
      next_q.led_failure_flag = 1'b0;
      next_q.blank_flag       = 1'b0;
    end
    if (fail_set) begin
      next_q.led_failure_flag = 1'b1;
    end
    if (blank_set) begin
      next_q.blank_flag = 1'b1;
    end

    // interrupt status
    events            = '0;
    events[IRQ_FAIL]  = fail_set && !q.led_failure_flag;
    events[IRQ_TO]    = tif.expired;
    events[IRQ_BLANK] = blank_set && !q.blank_flag;
    events[IRQ_WDOG]  = wdog_evt;
    if (wr && (addr == ADDR_IRQ_STATUS)) begin
      next_q.irq_status = q.irq_status & ~wdata[IRQ_W-1:0];
    end
    next_q.irq_status = next_q.irq_status | events;

    // read data, one cycle after the strobe
    if (rd) begin
      case (addr)
        ADDR_MODE_COPY:  next_q.rdata = {1'b0, q.mode, 5'h00};
        ADDR_FLASH:      next_q.rdata = {q.s2[SYN_VM], q.mode, q.outer_led_flash_level,
                                         q.centre_led_flash_level};
        ADDR_TIMER:      next_q.rdata = {q.safety_time_code, q.led_failure_flag, q.timeout_flag,
                                         q.timer_trigger_type, q.fl != FL_IDLE, q.blank_flag};
        ADDR_IRQ_STATUS: next_q.rdata = {{(8-IRQ_W){1'b0}}, q.irq_status};
        ADDR_IRQ_MASK:   next_q.rdata = {{(8-IRQ_W){1'b0}}, q.irq_mask};
        default:         next_q.rdata = 8'h00;
      endcase
    end

    // outputs
    blank_now          = q.blank_en && q.s2[SYN_TXM];
    next_q.mode_out    = next_q.mode;
    next_q.vm_out      = next_q.voltage_mode_force || q.s2[SYN_VM] || (next_q.mode == MODE_VSRC);
    next_q.flash_out   = (next_q.fl != FL_IDLE);
    next_q.blank_out   = blank_now;
    if (next_q.flash_out && !blank_now) begin
      next_q.outer_ma  = outer_ma(q.s2[SYN_HC], q.outer_led_flash_level);
      next_q.centre_ma = centre_ma(q.s2[SYN_HC], q.centre_led_flash_level);
    end else begin
      next_q.outer_ma  = 12'h000;
      next_q.centre_ma = 12'h000;
    end
    next_q.irq = |(next_q.irq_status & next_q.irq_mask);
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q                        <= '0;
      q.voltage_mode_force     <= RST_VM;
      q.mode                   <= MODE_SHUTDOWN;
      q.outer_led_flash_level  <= RST_FC13;
      q.centre_led_flash_level <= RST_FC2;
      q.safety_time_code       <= RST_STIM;
      q.timer_range_sel        <= RST_RANGE;
      q.timer_trigger_type     <= RST_STT;
      q.blank_en               <= RST_TXM;
      q.fl                     <= FL_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign rdata                 = q.rdata;
  assign operating_mode        = q.mode_out;
  assign voltage_mode          = q.vm_out;
  assign flash_active          = q.flash_out;
  assign blanking              = q.blank_out;
  assign outer_led_current_ma  = q.outer_ma;
  assign centre_led_current_ma = q.centre_ma;
  assign irq                   = q.irq;

  // ************************************************************
  // assertions
  // ************************************************************
  a_vm_readback: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == ADDR_FLASH) |=> (rdata[B_VM] == $past(q.s2[SYN_VM])))
    else $error("voltage mode bit does not read the pin");

  a_mode_copy02: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == ADDR_FLASH) ##1 (rd && addr == ADDR_MODE_COPY)
      |=> (rdata[B_MODE_LO +: 2] == $past(wdata[B_MODE_LO +: 2], 2)))
    else $error("mode copy at 0x01 not updated");

  a_mode_copy01: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == ADDR_MODE_COPY) |=> (operating_mode == $past(wdata[B_MODE_LO +: 2])))
    else $error("mode at 0x02 not updated from 0x01");

  a_wdog_shutdown: assert property (@(posedge clk) disable iff (rst)
    (q.mode != MODE_SHUTDOWN && !wr && q.wdog_presc == 32'(TICK_CYCLES - 1)
      && q.wdog_ticks == 32'(WDOG_TICKS - 1)) |=> (operating_mode == MODE_SHUTDOWN))
    else $error("no shutdown after refresh timeout");

  a_fail_clear: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == ADDR_TIMER && !q.s2[SYN_FAULT]) |=> !q.led_failure_flag)
    else $error("failure flag survives read");

  a_timeout_set: assert property (@(posedge clk) disable iff (rst)
    tif.expired |=> (q.timeout_flag [*1] ##0 !$past(q.start)) or q.timeout_flag)
    else $error("timeout flag not set on expiry");

  a_strobe_start: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == ADDR_TIMER && wdata[B_SFT] && q.mode == MODE_FLASH && q.fl == FL_IDLE)
      |=> ##1 tif.running ##0 flash_active)
    else $error("strobe write did not start the flash");

  a_strobe_read: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == ADDR_TIMER) |=> (rdata[B_SFT] == $past(q.fl != FL_IDLE)))
    else $error("strobe bit does not show flash state");

  a_blank_cut: assert property (@(posedge clk) disable iff (rst)
    (q.blank_en && q.s2[SYN_TXM]) |=> (outer_led_current_ma == 12'h000 && centre_led_current_ma == 12'h000))
    else $error("current not reduced while blanking");

  a_blank_flag: assert property (@(posedge clk) disable iff (rst)
    (q.blank_en && q.s2[SYN_TXM]) |=> q.blank_flag)
    else $error("blanking flag not set");

  a_level_stop: assert property (@(posedge clk) disable iff (rst)
    (q.fl == FL_LEVEL && !q.s2[SYN_FSYNC]) |=> (q.fl == FL_IDLE) ##1 !tif.running)
    else $error("level flash did not stop");

endmodule

// ==== verification/flc_host_model.sv ====
// flc_host_model: host side of the register port, byte reads and writes
// assumes one clock; strobes launched right after a rising edge
`timescale 1ns/1ps
module flc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // ************************************************************
  // one-cycle write and read strobes
  // ************************************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
endmodule

// ==== verification/flc_regs_bench.sv ====
// flc_regs_bench: self-checking bench of the flash led control registers
// assumes short tick and refresh counts so flashes last about 100 cycles
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module flc_regs_bench;
  import flc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        vm_pin = 1'b0;
  logic        hc = 1'b0;
  logic        txm = 1'b0;
  logic        fault = 1'b0;
  logic        fsync = 1'b0;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        wr_stb;
  logic        rd;
  logic [1:0]  opm;
  logic        vmode;
  logic        fact;
  logic        blank;
  logic [11:0] outer;
  logic [11:0] centre;
  logic        irq;
  int          fails = 0;
  int          total_checks = 0;
  always #5 clk = ~clk;
  flc_host_model flc_host_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr_stb), .rd(rd));
  flc_regs #(.TICK_CYCLES(2), .WDOG_TICKS(200)) flc_regs_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr_stb), .rd(rd), .rdata(rdata),
    .voltage_mode_pin(vm_pin), .high_current_select(hc), .tx_mask_pin(txm), .led_fault_pin(fault),
    .flash_sync_pin(fsync), .operating_mode(opm), .voltage_mode(vmode), .flash_active(fact),
    .blanking(blank), .outer_led_current_ma(outer), .centre_led_current_ma(centre), .irq(irq));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    flc_host_model_i.wr_reg(a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    logic [7:0] d;
    flc_host_model_i.rd_reg(a, d);
    `CHK(n, e, d & m)
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    test_done();
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    cyc(10);
    rst <= 1'b0;
    rchk(8'h02, 8'hff, 8'h03, "reset flash reg");
    rchk(8'h03, 8'hff, 8'hc0, "reset timer reg");
    wr(8'h20, 8'hff);
    rchk(8'h20, 8'hff, 8'h00, "unmapped");
    vm_pin <= 1'b1;
    cyc(4);
    rchk(8'h02, 8'h80, 8'h80, "vm pin read");
    `CHK("vm out", 1'b1, vmode)
    vm_pin <= 1'b0;
    $display("test reset and pin done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h01, {1'b0, 2'(m), 5'h00});
      cyc(2);
      `CHK("mode", 2'(m), opm)
      rchk(8'h02, 8'h60, {1'b0, 2'(m), 5'h00}, "mirror 02");
    end
    `CHK("vsrc mode", 1'b1, vmode)
    wr(8'h02, 8'h2b);
    rchk(8'h01, 8'h60, 8'h20, "mirror 01");
    $display("test modes done");
    wr(8'h02, 8'h4b);
    wr(8'h03, 8'h0e);
    cyc(3);
    `CHK("flash on", 1'b1, fact)
    `CHK("outer lo", 12'd335, outer)
    `CHK("centre lo", 12'd500, centre)
    rchk(8'h03, 8'h0a, 8'h02, "active no to");
    cyc(80);
    `CHK("still on", 1'b1, fact)
    cyc(25);
    `CHK("timed out", 1'b0, fact)
    rchk(8'h03, 8'h0a, 8'h08, "to flag");
    wr(8'h03, 8'h08);
    fsync <= 1'b1;
    cyc(5);
    `CHK("level on", 1'b1, fact)
    fsync <= 1'b0;
    cyc(6);
    `CHK("level off", 1'b0, fact)
    wr(8'h03, 8'h0c);
    fsync <= 1'b1;
    cyc(5);
    `CHK("edge start", 1'b1, fact)
    fsync <= 1'b0;
    hc <= 1'b1;
    wr(8'h02, 8'h4b);
    wr(8'h03, 8'h0f);
    cyc(5);
    `CHK("outer hi", 12'd775, outer)
    `CHK("centre hi", 12'd1165, centre)
    rchk(8'h03, 8'h08, 8'h00, "to cleared");
    txm <= 1'b1;
    cyc(5);
    `CHK("blanking", 1'b1, blank)
    `CHK("blank outer", 12'd0, outer)
    txm <= 1'b0;
    cyc(3);
    rchk(8'h03, 8'h01, 8'h01, "blank flag");
    rchk(8'h03, 8'h01, 8'h00, "blank clr");
    $display("test flash done");
    wr(8'h11, 8'h01);
    fault <= 1'b1;
    cyc(4);
    fault <= 1'b0;
    cyc(2);
    `CHK("irq set", 1'b1, irq)
    rchk(8'h03, 8'h10, 8'h10, "fail flag");
    rchk(8'h03, 8'h10, 8'h00, "fail clr");
    wr(8'h10, 8'h01);
    cyc(1);
    `CHK("irq clr", 1'b0, irq)
    $display("test fault done");
    wr(8'h02, 8'h2b);
    cyc(370);
    `CHK("refresh kept", 2'h1, opm)
    cyc(60);
    `CHK("refresh lost", 2'h0, opm)
    $display("test refresh done");
    test_done();
  end
endmodule
